// file: inc/ffir_pkg.sv
// constants and types for the fault flag and identity register block
package ffir_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ID_OFF = 8'h00;
    localparam logic [7:0] FLT_OFF = 8'h01;
    localparam logic [4:0] FLT_RESET = 5'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int FLT_STARTUP_BIT = 4;
    localparam int FLT_LOCKOUT_BIT = 3;
    localparam int FLT_TEMP_BIT = 2;
    localparam int FLT_SHORT_BIT = 1;
    localparam int FLT_ILIM_BIT = 0;
    localparam logic [6:0] SLAVE_ADDR = 7'h20;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 50;
    localparam int ILIM_TIME_US = 500;
    localparam int HOLD_TIME_MS = 100;
    localparam int ILIM_CYC = ILIM_TIME_US * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_TIME_MS * 1000 * CLK_MHZ;

    // ****************************************************************
    // serial engine states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_ADDR = 4'h2,
        ST_REGA = 4'h3,
        ST_ACK_REG = 4'h4,
        ST_WDATA = 4'h5,
        ST_ACK_WR = 4'h6,
        ST_RDATA = 4'h7,
        ST_MACK = 4'h8
    } ffir_state_e;
endpackage

// file: hw/ffir_regs.sv
// serial slave with identity register and read-to-clear fault flags
`timescale 1ns/1ns
// Operation
// - identity register: product code in bits 7:4, silicon revision in 3:0.
// - startup timeout event sets and holds fault bit 4.
// - input lockout event sets and holds fault bit 3.
// - over-temperature event sets and holds fault bit 2.
// - output short event sets and holds fault bit 1.
// - bit 0 sets only after peak limit held 500 us in PWM.
// - reading fault register returns old flags, then clears them.
// - serial clock held low over 100 ms returns all registers to default.
module ffir_regs #(
    parameter int ILIM_CYCLES = ffir_pkg::ILIM_CYC,
    parameter int HOLD_CYCLES = ffir_pkg::HOLD_CYC,
    parameter logic [3:0] PRODUCT_ID = 4'h5, // arbitrary value
    parameter logic [3:0] SILICON_REV = 4'h3 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_startup_timeout,
    input wire logic i_input_lockout,
    input wire logic i_over_temp,
    input wire logic i_output_short,
    input wire logic i_peak_ilim,
    input wire logic i_pwm_mode,
    output logic o_hw_reset
);
    import ffir_pkg::*;
    default clocking ffir_cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ****************************************************************
    // state
    // ****************************************************************
    localparam int IW = $clog2(ILIM_CYCLES + 1);
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam logic [IW-1:0] ILIM_MAX = IW'(ILIM_CYCLES);
    localparam logic [HW-1:0] HOLD_MAX = HW'(HOLD_CYCLES);

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl;
        logic sda;
        ffir_state_e st;
        logic [2:0] cnt;
        logic full;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic [7:0] obyte;
        logic [4:0] flags;
        logic [IW-1:0] ilim_cnt;
        logic [HW-1:0] hold_cnt;
        logic sda_oe;
        logic sda_out;
        logic hw_rst;
    } ffir_q_s;

    ffir_q_s q;
    ffir_q_s next_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic ilim_hit;
    logic hw_clear;
    logic load_flt;
    logic [4:0] ev;
    logic [4:0] clr;
    logic [7:0] rd_ptr;

    function automatic logic [7:0] rd_reg(input logic [7:0] p,
                                          input logic [4:0] f);
        if (p == ID_OFF) begin
            rd_reg = {PRODUCT_ID, SILICON_REV};
        end else if (p == FLT_OFF) begin
            rd_reg = {3'h0, f};
        end else begin
            rd_reg = 8'h00;
        end
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_q = q;
        rd_ptr = q.ptr;
        load_flt = 1'b0;
        clr = 5'h00;
        // three stages; a level counts once stages two and three agree
        next_q.scl_s = {q.scl_s[1:0], i_scl};
        next_q.sda_s = {q.sda_s[1:0], i_sda};
        if (q.scl_s[2] == q.scl_s[1]) begin
            next_q.scl = q.scl_s[2];
        end
        if (q.sda_s[2] == q.sda_s[1]) begin
            next_q.sda = q.sda_s[2];
        end
        rise = next_q.scl & ~q.scl;
        fall = ~next_q.scl & q.scl;
        start = q.scl & next_q.scl & q.sda & ~next_q.sda;
        stop = q.scl & next_q.scl & ~q.sda & next_q.sda;

        // peak limit must stay up without a gap in PWM operation
        ilim_hit = i_pwm_mode && i_peak_ilim && q.ilim_cnt == ILIM_MAX - 1'b1;
        if (i_pwm_mode && i_peak_ilim) begin
            if (q.ilim_cnt != ILIM_MAX) begin
                next_q.ilim_cnt = q.ilim_cnt + 1'b1;
            end
        end else begin
            next_q.ilim_cnt = '0;
        end

        ev = 5'h00;
        ev[FLT_STARTUP_BIT] = i_startup_timeout;
        ev[FLT_LOCKOUT_BIT] = i_input_lockout;
        ev[FLT_TEMP_BIT] = i_over_temp;
        ev[FLT_SHORT_BIT] = i_output_short;
        ev[FLT_ILIM_BIT] = ilim_hit;

        if (start) begin
            next_q.st = ST_ADDR;
            next_q.cnt = 3'h0;
            next_q.full = 1'b0;
            next_q.sda_oe = 1'b0;
        end else if (stop) begin
            next_q.st = ST_IDLE;
            next_q.sda_oe = 1'b0;
        end else if (rise) begin
            if (q.st == ST_MACK) begin
                next_q.nack = q.sda;
            end else if (q.st == ST_ADDR || q.st == ST_REGA ||
                         q.st == ST_WDATA || q.st == ST_RDATA) begin
                next_q.sh = {q.sh[6:0], q.sda};
                next_q.cnt = q.cnt + 3'h1;
                next_q.full = (q.cnt == 3'h7);
            end
        end else if (fall) begin
            case (q.st)
                ST_ADDR: begin
                    if (q.full) begin
                        next_q.full = 1'b0;
                        if (q.sh[7:1] == SLAVE_ADDR) begin
                            next_q.st = ST_ACK_ADDR;
                            next_q.sda_oe = 1'b1;
                            next_q.rw = q.sh[0];
                        end else begin
                            next_q.st = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (q.rw) begin
                        load_flt = 1'b1;
                        next_q.st = ST_RDATA;
                    end else begin
                        next_q.sda_oe = 1'b0;
                        next_q.st = ST_REGA;
                    end
                end
                ST_REGA: begin
                    if (q.full) begin
                        next_q.full = 1'b0;
                        next_q.ptr = q.sh;
                        next_q.st = ST_ACK_REG;
                        next_q.sda_oe = 1'b1;
                    end
                end
                ST_ACK_REG: begin
                    next_q.sda_oe = 1'b0;
                    next_q.st = ST_WDATA;
                end
                ST_WDATA: begin
                    // write data is acked and dropped
                    if (q.full) begin
                        next_q.full = 1'b0;
                        next_q.st = ST_ACK_WR;
                        next_q.sda_oe = 1'b1;
                    end
                end
                ST_ACK_WR: begin
                    next_q.sda_oe = 1'b0;
                    next_q.ptr = q.ptr + 8'h01;
                    next_q.st = ST_WDATA;
                end
                ST_RDATA: begin
                    if (q.full) begin
                        next_q.full = 1'b0;
                        next_q.sda_oe = 1'b0;
                        next_q.st = ST_MACK;
                    end else begin
                        next_q.sda_oe = ~q.obyte[3'h7 - q.cnt];
                    end
                end
                ST_MACK: begin
                    if (q.nack) begin
                        next_q.st = ST_IDLE;
                    end else begin
                        rd_ptr = q.ptr + 8'h01;
                        next_q.ptr = rd_ptr;
                        load_flt = 1'b1;
                        next_q.st = ST_RDATA;
                    end
                end
                default: begin
                    next_q.st = ST_IDLE;
                end
            endcase
        end

        if (load_flt) begin
            // byte is captured before the clear takes effect
            next_q.obyte = rd_reg(rd_ptr, q.flags);
            next_q.sda_oe = ~next_q.obyte[7];
            next_q.cnt = 3'h0;
            if (rd_ptr == FLT_OFF) begin
                clr = 5'h1f;
            end
        end
        // a new event in the clearing cycle survives
        next_q.flags = (q.flags & ~clr) | ev;

        // serial clock held low long enough restores defaults
        hw_clear = ~next_q.scl && (q.hold_cnt == HOLD_MAX - 1'b1);
        if (next_q.scl) begin
            next_q.hold_cnt = '0;
        end else if (q.hold_cnt != HOLD_MAX) begin
            next_q.hold_cnt = q.hold_cnt + 1'b1;
        end
        next_q.hw_rst = hw_clear;
        if (hw_clear) begin
            next_q.st = ST_IDLE;
            next_q.flags = FLT_RESET;
            next_q.ptr = PTR_RESET;
            next_q.full = 1'b0;
            next_q.ilim_cnt = '0;
            next_q.sda_oe = 1'b0;
        end
        next_q.sda_out = 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_sda_out = q.sda_out;
    assign o_sda_oe = q.sda_oe;
    assign o_hw_reset = q.hw_rst;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_flt_load;
        load_flt && (rd_ptr == FLT_OFF) && !hw_clear;
    endsequence

    AST_ID_VALUE: assert property (
        load_flt && rd_ptr == ID_OFF |=> q.obyte == {PRODUCT_ID, SILICON_REV})
        else $error("identity byte wrong");
    AST_STARTUP_SET: assert property (
        (i_startup_timeout && !hw_clear) |=> q.flags[FLT_STARTUP_BIT])
        else $error("startup flag not set");
    AST_LOCKOUT_SET: assert property (
        (i_input_lockout && !hw_clear) |=> q.flags[FLT_LOCKOUT_BIT])
        else $error("lockout flag not set");
    AST_TEMP_HOLD: assert property (
        q.flags[FLT_TEMP_BIT] && !load_flt && !hw_clear
            |=> q.flags[FLT_TEMP_BIT])
        else $error("temperature flag lost");
    AST_SHORT_SET: assert property (
        (i_output_short && !hw_clear) ##1 !load_flt |-> q.flags[FLT_SHORT_BIT])
        else $error("short flag not set");
    AST_ILIM_ONLY_HELD: assert property (
        $rose(q.flags[FLT_ILIM_BIT]) |-> $past(q.ilim_cnt) == ILIM_MAX - 1'b1)
        else $error("limit flag set without full hold");
    AST_READ_CLEAR: assert property (
        s_flt_load ##0 (ev == 5'h00) |=> (q.flags == 5'h00) &&
            (q.obyte == {3'h0, $past(q.flags)}))
        else $error("read did not return and clear flags");
    AST_UNUSED_ZERO: assert property (
        s_flt_load |=> (q.obyte[7:5] == 3'h0))
        else $error("unused fault bits not zero");
    AST_HOLD_RESET: assert property (
        hw_clear |=> (q.flags == FLT_RESET) && (q.st == ST_IDLE) && o_hw_reset)
        else $error("hold reset did not restore defaults");
endmodule

// file: verification/ffir_master_model.sv
// i2c master model for register reads, writes and scl hold
`timescale 1ns/1ns
module ffir_master_model
    import ffir_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda,
    output logic o_sda_wire
);
    // open drain with pull-up: a released line reads high
    assign o_sda_wire = o_sda & ~i_sda_oe;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // 8 clk per phase stays clear of the input filter delay
    task automatic drive(input logic c, input logic d);
        o_scl = c;
        o_sda = d;
        step(8);
    endtask
    task automatic put_bit(input logic b, output logic r);
        drive(1'b0, b);
        drive(1'b1, b);
        r = o_sda_wire;
        drive(1'b0, b);
    endtask
    task automatic start_cond();
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask
    task automatic byte_io(input logic [7:0] b, output logic [7:0] got,
                           output logic nak);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], got[i]);
        end
        put_bit(1'b1, nak);
    endtask
    // ninth bit always released: ack slot on writes, nack on reads
    task automatic transfer(input logic rd, input logic [7:0] a,
                            input logic [7:0] v, output logic [7:0] d,
                            output logic nak);
        logic n1, n2, n3, nx;
        start_cond();
        byte_io({SLAVE_ADDR, 1'b0}, d, n1);
        byte_io(a, d, n2);
        if (rd) begin
            start_cond();
            byte_io({SLAVE_ADDR, 1'b1}, d, n3);
            byte_io(8'hff, d, nx);
        end else begin
            byte_io(v, d, n3);
        end
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
        nak = n1 | n2 | n3;
    endtask
    // two-byte read: master acks the first byte and nacks the second
    task automatic read2(input logic [7:0] a, output logic [7:0] d0,
                         output logic [7:0] d1, output logic nak);
        logic n1, n2, n3, ma, nx;
        logic [7:0] t;
        start_cond();
        byte_io({SLAVE_ADDR, 1'b0}, t, n1);
        byte_io(a, t, n2);
        start_cond();
        byte_io({SLAVE_ADDR, 1'b1}, t, n3);
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d0[i]);
        end
        put_bit(1'b0, ma);
        byte_io(8'hff, d1, nx);
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
        nak = n1 | n2 | n3;
    endtask
    task automatic hold_scl_low(input int n);
        o_scl = 1'b0;
        step(n);
        drive(1'b1, 1'b1);
    endtask
endmodule

// file: verification/fault_flag_and_id_registers_test.sv
// self-checking bench for the fault flag and identity registers
`timescale 1ns/1ns
module fault_flag_and_id_registers_test;
    import ffir_pkg::*;
    localparam int ILIM_N = 20;
    localparam int HOLD_N = 50;
    localparam logic [3:0] PROD = 4'h5; // arbitrary value
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    logic clk, rst, scl, sda, sda_out, sda_oe, pwm, ilim, hw_rst;
    int n_rst = 0;
    logic [4:1] ev;
    logic [7:0] d;
    logic nak;
    int failures;
    int num_checks;
    ffir_regs #(.ILIM_CYCLES(ILIM_N), .HOLD_CYCLES(HOLD_N),
        .PRODUCT_ID(PROD), .SILICON_REV(REV)) ffir_regs_i (
        .i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_startup_timeout(ev[FLT_STARTUP_BIT]),
        .i_input_lockout(ev[FLT_LOCKOUT_BIT]),
        .i_over_temp(ev[FLT_TEMP_BIT]), .i_output_short(ev[FLT_SHORT_BIT]),
        .i_peak_ilim(ilim), .i_pwm_mode(pwm), .o_hw_reset(hw_rst));
    ffir_master_model ffir_master_model_i (.i_clk(clk), .i_sda_oe(sda_oe),
        .o_scl(scl), .o_sda(), .o_sda_wire(sda));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count hold reset pulses; each is one cycle wide
    always @(posedge clk) begin
        if (hw_rst === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        ffir_master_model_i.transfer(1'b1, a, 8'h00, d, nak);
        cmp1(1'b0, nak);
        cmp8(exp, d);
        cmp1(1'b0, sda_out);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        ffir_master_model_i.transfer(1'b0, a, v, d, nak);
        cmp1(1'b0, nak);
    endtask
    task automatic pulse(input logic [4:1] m);
        ev = m;
        tick(1);
        ev = 4'h0;
        tick(2);
    endtask
    task automatic scn_identity();
        rd(FLT_OFF, 8'h00);
        rd(ID_OFF, {PROD, REV});
        wr(ID_OFF, 8'hff);
        rd(ID_OFF, {PROD, REV});
        rd(8'h05, 8'h00);
    endtask
    task automatic scn_events();
        for (int b = 1; b <= 4; b++) begin
            pulse(4'h1 << (b - 1));
            rd(FLT_OFF, 8'h01 << b);
            rd(FLT_OFF, 8'h00);
        end
        pulse(4'hf);
        wr(FLT_OFF, 8'h00);
        rd(FLT_OFF, 8'h1e);
    endtask
    // two-byte read: identity, then flags through the pointer increment
    task automatic scn_burst();
        logic [7:0] d1;
        pulse(4'h2);
        ffir_master_model_i.read2(ID_OFF, d, d1, nak);
        cmp1(1'b0, nak);
        cmp8({PROD, REV}, d);
        cmp8(8'h04, d1);
        rd(FLT_OFF, 8'h00);
    endtask
    // one cycle short, a gap, then pwm dropped: none may set bit 0
    task automatic scn_ilim();
        pwm = 1'b1;
        ilim = 1'b1;
        tick(ILIM_N - 1);
        ilim = 1'b0;
        tick(1);
        ilim = 1'b1;
        tick(ILIM_N - 1);
        pwm = 1'b0;
        tick(ILIM_N + 5);
        pwm = 1'b1;
        ilim = 1'b0;
        rd(FLT_OFF, 8'h00);
        ilim = 1'b1;
        tick(ILIM_N);
        ilim = 1'b0;
        tick(2);
        rd(FLT_OFF, 8'h01);
    endtask
    task automatic scn_hold();
        int base;
        pulse(4'h1);
        base = n_rst;
        ffir_master_model_i.hold_scl_low(HOLD_N - 5);
        cmp1(1'b0, n_rst != base);
        rd(FLT_OFF, 8'h02);
        pulse(4'h1);
        ffir_master_model_i.hold_scl_low(HOLD_N + 10);
        cmp1(1'b1, n_rst == base + 1);
        rd(FLT_OFF, 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        ev = 4'h0;
        pwm = 1'b0;
        ilim = 1'b0;
        failures = 0;
        num_checks = 0;
        tick(16);
        rst = 1'b0;
        tick(10);
        scn_identity();
        scn_events();
        scn_burst();
        scn_ilim();
        scn_hold();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule
